// ===== pwrs_evsched.v
// One schedule of the event/RTC action scheduler, advanced by the minute tick
`timescale 1ns/1ps
`include "pwrs_regs.vh"
module pwrs_evsched (
   input wire clk,
   input wire rst_n,
   input wire run,
   input wire tick,
   input wire [7:0] hour,
   input wire [7:0] minute,
   input wire ext_event,
   input wire [7:0] ctrl,
   input wire [7:0] start_hour,
   input wire [7:0] start_min,
   input wire [7:0] dur,
   input wire [7:0] rep,
   input wire [7:0] mult,
   input wire [7:0] seq_hours,
   output reg act
);
   localparam E_WAIT = 2'd0, E_SEQ = 2'd1, E_DONE = 2'd2;
   reg [1:0] st;
   reg [7:0] dur_cnt, rep_cnt, occ_left;
   reg [13:0] seq_cnt;
   wire [13:0] seq_len = {seq_hours, 6'h00} - {4'h0, seq_hours, 2'h0};
   wire trig = ctrl[`PWRS_EVC_TRIG] ? ext_event : (hour == start_hour && minute == start_min);
   wire act_ends = !act || dur_cnt <= 8'h01;
   always @(posedge clk)
   begin
      if (!rst_n || !run || !ctrl[`PWRS_EVC_EN])
      begin
         st <= E_WAIT; act <= 1'b0; dur_cnt <= 8'h00; rep_cnt <= 8'h00;
         occ_left <= 8'h00; seq_cnt <= 14'h0000;
      end
      else if (tick)
      begin
         case (st)
            E_WAIT:
               if (trig)
               begin
                  st <= E_SEQ; act <= 1'b1; dur_cnt <= dur; rep_cnt <= rep;
                  occ_left <= mult; seq_cnt <= seq_len;
               end
            E_SEQ:
            begin
               if (seq_cnt != 14'h0000)
                  seq_cnt <= seq_cnt - 14'h0001;
               if (act_ends)
                  act <= 1'b0;
               else
                  dur_cnt <= dur_cnt - 8'h01;
               if (rep_cnt != 8'h00)
                  rep_cnt <= rep_cnt - 8'h01;
               if (occ_left > 8'h01 && rep != 8'h00 && rep_cnt <= 8'h01)
               begin
                  act <= 1'b1; dur_cnt <= dur; rep_cnt <= rep; occ_left <= occ_left - 8'h01;
               end
               else if (occ_left <= 8'h01 && act_ends)
               begin
                  if (seq_hours == 8'h00)
                     st <= E_DONE;
                  else if (seq_cnt <= 14'h0001)
                  begin
                     act <= 1'b1; dur_cnt <= dur; rep_cnt <= rep;
                     occ_left <= mult; seq_cnt <= seq_len;
                  end
               end
            end
            E_DONE: ;
            default: st <= E_WAIT;
         endcase
      end
   end
endmodule

// ===== pwrs_host_model.sv
// Host I2C controller model that reaches the scheduler registers
`timescale 1ns/1ps
`include "pwrs_regs.vh"
module pwrs_host_model (
   input wire clk,
   input wire sda_in,
   output reg scl,
   output reg sda_low
);
   reg nak;
   reg [7:0] q;
   initial
   begin
      scl = 1'b1;
      sda_low = 1'b0;
      nak = 1'b0;
   end
   // SCL high time, a third of each bit period; the target needs at least 4 clocks
   task hp;
      repeat (6) @(negedge clk);
   endtask
   // Data moves only while SCL is low and is read while SCL is high
   task xbit(input b, output r);
   begin
      sda_low = ~b;
      hp;
      scl = 1'b1;
      hp;
      r = sda_in;
      scl = 1'b0;
      hp;
   end
   endtask
   // s high gives a start, s low a stop
   task cond(input s);
   begin
      sda_low = ~s;
      hp;
      scl = 1'b1;
      hp;
      sda_low = s;
      hp;
      scl = ~s;
      hp;
   end
   endtask
   task xbyte(input [7:0] d);
      integer i;
      reg a;
   begin
      for (i = 7; i >= 0; i = i - 1)
         xbit(d[i], q[i]);
      xbit(1'b1, a);
      nak = nak | a;
   end
   endtask
   task wr(input [7:0] a, input [7:0] d);
   begin
      nak = 1'b0;
      cond(1'b1);
      xbyte({`PWRS_I2C_ADDR, 1'b0});
      xbyte(a);
      xbyte(d);
      cond(1'b0);
   end
   endtask
   // Pointer set, then a one-byte read closed by a not-acknowledge
   task rd(input [7:0] a, output [7:0] d);
      reg k;
   begin
      nak = 1'b0;
      cond(1'b1);
      xbyte({`PWRS_I2C_ADDR, 1'b0});
      xbyte(a);
      cond(1'b0);
      cond(1'b1);
      xbyte({`PWRS_I2C_ADDR, 1'b1});
      // The closing not-acknowledge is ours, so it is kept out of nak
      k = nak;
      xbyte(8'hff);
      nak = k;
      d = q;
      cond(1'b0);
   end
   endtask
endmodule

// ===== pwrs_i2c.v
// I2C target with register pointer, auto-increment and single-cycle write strobe
`timescale 1ns/1ps
`include "pwrs_regs.vh"
module pwrs_i2c #(
   parameter [6:0] DEV_ADDR = `PWRS_I2C_ADDR
)(
   input wire clk,
   input wire rst_n,
   input wire scl_in,
   input wire sda_in,
   output reg sda_out,
   output reg sda_oe,
   input wire [7:0] rd_data,
   output reg [7:0] ptr,
   output reg wr_stb,
   output reg [7:0] wr_data
);
   localparam I_IDLE = 3'd0, I_ADDR = 3'd1, I_ACKA = 3'd2, I_WR = 3'd3;
   localparam I_ACKW = 3'd4, I_RD = 3'd5, I_RACK = 3'd6, I_RLOAD = 3'd7;
   reg scl_q, sda_q, rw, first;
   reg [2:0] st;
   reg [3:0] bitc;
   reg [7:0] sh;
   wire rise = scl_in & ~scl_q;
   wire fall = ~scl_in & scl_q;
   wire start = scl_in & scl_q & sda_q & ~sda_in;
   wire stop = scl_in & scl_q & ~sda_q & sda_in;
   always @(posedge clk)
   begin
      wr_stb <= 1'b0;
      if (!rst_n)
      begin
         scl_q <= 1'b1; sda_q <= 1'b1; st <= I_IDLE; bitc <= 4'h0; sh <= 8'h00;
         rw <= 1'b0; first <= 1'b0; ptr <= 8'h00; wr_data <= 8'h00;
         sda_out <= 1'b0; sda_oe <= 1'b0;
      end
      else
      begin
         scl_q <= scl_in;
         sda_q <= sda_in;
         // Step the pointer only after the store has used the old one
         if (wr_stb)
            ptr <= ptr + 8'h01;
         if (start)
         begin
            st <= I_ADDR; bitc <= 4'h0; first <= 1'b1; sda_oe <= 1'b0;
         end
         else if (stop)
         begin
            st <= I_IDLE; sda_oe <= 1'b0;
         end
         else if (rise)
         begin
            if (st == I_ADDR || st == I_WR)
            begin
               sh <= {sh[6:0], sda_in}; bitc <= bitc + 4'h1;
            end
            if (st == I_RD)
               bitc <= bitc + 4'h1;
            if (st == I_RACK)
               st <= sda_in ? I_IDLE : I_RLOAD;
         end
         else if (fall)
         begin
            case (st)
               I_ADDR:
                  if (bitc == 4'h8)
                  begin
                     rw <= sh[0];
                     st <= (sh[7:1] == DEV_ADDR) ? I_ACKA : I_IDLE;
                     sda_oe <= (sh[7:1] == DEV_ADDR);
                  end
               I_ACKA, I_RLOAD:
                  if (rw)
                  begin
                     sh <= rd_data; sda_oe <= ~rd_data[7]; st <= I_RD; bitc <= 4'h0;
                  end
                  else
                  begin
                     sda_oe <= 1'b0; st <= I_WR; bitc <= 4'h0;
                  end
               I_WR:
                  if (bitc == 4'h8)
                  begin
                     if (first)
                        ptr <= sh;
                     else
                     begin
                        wr_stb <= 1'b1; wr_data <= sh;
                     end
                     first <= 1'b0; sda_oe <= 1'b1; st <= I_ACKW;
                  end
               I_ACKW:
               begin
                  sda_oe <= 1'b0; st <= I_WR; bitc <= 4'h0;
               end
               I_RD:
                  if (bitc == 4'h8)
                  begin
                     sda_oe <= 1'b0; st <= I_RACK; ptr <= ptr + 8'h01;
                  end
                  else
                  begin
                     sda_oe <= ~sh[6]; sh <= {sh[6:0], 1'b0};
                  end
               default: ;
            endcase
         end
      end
   end
endmodule

// ===== pwrs_regs.vh
// Register offsets, field positions, reset values and timing for the power scheduler
`ifndef PWRS_REGS_VH
`define PWRS_REGS_VH
`define PWRS_I2C_ADDR 7'h6b
`define PWRS_OFS_SELECT 8'h20
`define PWRS_OFS_ON 8'h21
`define PWRS_OFS_OFF 8'h22
`define PWRS_OFS_CYCLES 8'h23
`define PWRS_OFS_RUN 8'h24
`define PWRS_OFS_EV_RUN 8'h28
`define PWRS_OFS_STATUS 8'h29
`define PWRS_EV_AREA 3'h2
`define PWRS_SEL_SIMPLE 8'h01
`define PWRS_SEL_EVENT 8'h02
`define PWRS_RUN_NOW 8'hff
`define PWRS_RUN_MIDNIGHT 8'hfb
`define PWRS_RUN_STOP 8'h00
`define PWRS_CYC_FOREVER 8'hff
`define PWRS_RST_SELECT 8'h01
`define PWRS_RST_ON 8'h01
`define PWRS_RST_OFF 8'h01
`define PWRS_RST_CYCLES 8'hff
`define PWRS_RST_RUN 8'h00
`define PWRS_BATT_UNLIMITED 8'hff
`define PWRS_BATT_DEFAULT 8'h01
`define PWRS_EVF_CTRL 3'h0
`define PWRS_EVF_HOUR 3'h1
`define PWRS_EVF_MIN 3'h2
`define PWRS_EVF_DUR 3'h3
`define PWRS_EVF_REP 3'h4
`define PWRS_EVF_MULT 3'h5
`define PWRS_EVF_SEQ 3'h6
`define PWRS_EVC_EN 0
`define PWRS_EVC_TGT 2:1
`define PWRS_EVC_TRIG 3
`define PWRS_TGT_HOST 2'h0
`define PWRS_TGT_AUX 2'h1
`define PWRS_TGT_RELAY 2'h2
`define PWRS_CLK_NS 8
`define PWRS_LED_FLASH_NS 50000000
`define PWRS_LED_PERIOD_NS 1000000000
`endif

// ===== pwrs_sched_properties.sv
// Port-level assertions for the power scheduler
`timescale 1ns/1ps
module pwrs_sched_properties #(
   parameter integer LED_FLASH_CYC = 5,
   parameter integer LED_PERIOD_CYC = 20
)(
   input wire clk,
   input wire rst_n,
   input wire rtc_minute_tick,
   input wire host_power_en,
   input wire aux_5v_en,
   input wire relay_set,
   input wire relay_reset,
   input wire information_indicator,
   input wire [7:0] batt_runtime_limit
);
   integer gap;
   // Cycles since the last flash began; saturates so a long idle spell cannot wrap
   always @(posedge clk)
      if (!rst_n)
         gap <= LED_PERIOD_CYC;
      else if ($rose(information_indicator))
         gap <= 1;
      else if (gap < 1000)
         gap <= gap + 1;
   default clocking dc @(posedge clk); endclocking
   default disable iff (!rst_n);
   // Outputs fed by the minute counters move two clocks after the tick
   sequence tick2_s;
      $past(rtc_minute_tick, 2);
   endsequence
   sequence pulse_s;
      (relay_set || relay_reset) ##1 !(relay_set || relay_reset);
   endsequence
   flash_gap_a: assert property ($rose(information_indicator) |-> gap >= LED_PERIOD_CYC)
      else $error("indicator flashes too close together");
   flash_len_a: assert property (information_indicator && !$rose(information_indicator)
      |-> gap < LED_FLASH_CYC) else $error("indicator flash too long");
   batt_code_a: assert property (batt_runtime_limit == 8'hff || batt_runtime_limit == 8'h01)
      else $error("battery limit has an odd value");
   batt_end_a: assert property ($fell(batt_runtime_limit == 8'hff) |-> ##[0:2] !host_power_en)
      else $error("host still powered after scheduler end");
   pwr_fall_a: assert property ($fell(host_power_en) |-> tick2_s)
      else $error("host power dropped off the minute tick");
   aux_rise_a: assert property ($rose(aux_5v_en) |-> tick2_s)
      else $error("aux output started off the minute tick");
   relay_pulse_a: assert property (relay_set || relay_reset |-> pulse_s)
      else $error("relay pulse not one cycle");
   relay_time_a: assert property (relay_set |-> !relay_reset ##0 tick2_s)
      else $error("relay set off the tick or with reset");
endmodule

// ===== pwrs_top.v
// Power scheduler: I2C registers, simple timed scheduler and four event schedules
`timescale 1ns/1ps
`include "pwrs_regs.vh"
module pwrs_top #(
   parameter [6:0] DEV_ADDR = `PWRS_I2C_ADDR,
   parameter integer NUM_SCHED = 4,
   parameter integer LED_FLASH_CYC = `PWRS_LED_FLASH_NS / `PWRS_CLK_NS,
   parameter integer LED_PERIOD_CYC = `PWRS_LED_PERIOD_NS / `PWRS_CLK_NS
)(
   input wire clk,
   input wire rst_n,
   input wire scl_in,
   input wire sda_in,
   output wire sda_out,
   output wire sda_oe,
   input wire rtc_minute_tick,
   input wire [7:0] rtc_hour,
   input wire [7:0] rtc_minute,
   input wire cable_powered,
   input wire [NUM_SCHED-1:0] ext_event,
   output reg host_power_en,
   output reg aux_5v_en,
   output reg relay_set,
   output reg relay_reset,
   output reg information_indicator,
   output reg [7:0] batt_runtime_limit
);
   localparam SS_IDLE = 2'd0, SS_ARMED = 2'd1, SS_ON = 2'd2, SS_OFF = 2'd3;
   wire [7:0] ptr;
   wire wr_stb;
   wire [7:0] wr_data;
   reg [7:0] rd_data;
   reg [7:0] scheduler_select;
   reg [7:0] on_minutes;
   reg [7:0] off_minutes;
   reg [7:0] cycle_count;
   reg [7:0] run_control;
   reg event_run;
   reg [NUM_SCHED*64-1:0] ev_cfg;
   reg [1:0] ss;
   reg stop_pend;
   reg [7:0] on_cnt, off_cnt, cyc_cnt;
   reg [26:0] led_cnt;
   reg relay_state;
   wire [NUM_SCHED-1:0] ev_act;
   wire [NUM_SCHED-1:0] ev_host, ev_aux, ev_relay;
   wire simple_sel = scheduler_select == `PWRS_SEL_SIMPLE;
   wire event_sel = scheduler_select == `PWRS_SEL_EVENT;
   wire ev_running = event_sel && event_run;
   wire simple_active = ss != SS_IDLE;
   wire midnight = rtc_hour == 8'h00 && rtc_minute == 8'h00;
   wire in_ev_area = ptr[7:5] == `PWRS_EV_AREA && {3'h0, ptr[4:3]} < NUM_SCHED;
   wire cyc_last = cycle_count != `PWRS_CYC_FOREVER && cyc_cnt <= 8'h01;
   wire prog_ok = cable_powered;

   pwrs_i2c #(
      .DEV_ADDR(DEV_ADDR)
   ) u_i2c (
      .clk(clk),
      .rst_n(rst_n),
      .scl_in(scl_in),
      .sda_in(sda_in),
      .sda_out(sda_out),
      .sda_oe(sda_oe),
      .rd_data(rd_data),
      .ptr(ptr),
      .wr_stb(wr_stb),
      .wr_data(wr_data)
   );

   // Plain register stores; the simple scheduler's own registers lock on battery
   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         scheduler_select <= `PWRS_RST_SELECT;
         on_minutes <= `PWRS_RST_ON;
         off_minutes <= `PWRS_RST_OFF;
         cycle_count <= `PWRS_RST_CYCLES;
         event_run <= 1'b0;
         ev_cfg <= {NUM_SCHED*64{1'b0}};
      end
      else if (wr_stb)
      begin
         if (ptr == `PWRS_OFS_SELECT && prog_ok && !simple_active && !event_run)
            scheduler_select <= wr_data;
         if (ptr == `PWRS_OFS_ON && prog_ok && wr_data != 8'h00)
            on_minutes <= wr_data;
         if (ptr == `PWRS_OFS_OFF && prog_ok && wr_data != 8'h00)
            off_minutes <= wr_data;
         if (ptr == `PWRS_OFS_CYCLES && prog_ok && wr_data != 8'h00)
            cycle_count <= wr_data;
         if (ptr == `PWRS_OFS_EV_RUN)
            event_run <= wr_data[0];
         // Schedule settings are frozen while the event scheduler runs
         if (in_ev_area && !event_run)
            ev_cfg[{ptr[4:0], 3'h0} +: 8] <= wr_data;
      end
   end

   // Simple timed scheduler
   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         ss <= SS_IDLE;
         stop_pend <= 1'b0;
         on_cnt <= 8'h00;
         off_cnt <= 8'h00;
         cyc_cnt <= 8'h00;
         run_control <= `PWRS_RST_RUN;
         batt_runtime_limit <= `PWRS_BATT_DEFAULT;
      end
      else if (!simple_sel)
      begin
         // Leaving the simple scheduler drops it without waiting for a phase end
         ss <= SS_IDLE;
         stop_pend <= 1'b0;
         if (simple_active)
         begin
            run_control <= `PWRS_RUN_STOP;
            batt_runtime_limit <= `PWRS_BATT_DEFAULT;
         end
      end
      else if (wr_stb && ptr == `PWRS_OFS_RUN && prog_ok)
      begin
         run_control <= wr_data;
         if (wr_data == `PWRS_RUN_NOW)
         begin
            ss <= SS_ON;
            on_cnt <= on_minutes;
            off_cnt <= off_minutes;
            cyc_cnt <= cycle_count;
            stop_pend <= 1'b0;
            batt_runtime_limit <= `PWRS_BATT_UNLIMITED;
         end
         else if (wr_data == `PWRS_RUN_MIDNIGHT)
         begin
            ss <= SS_ARMED;
            cyc_cnt <= cycle_count;
            stop_pend <= 1'b0;
            batt_runtime_limit <= `PWRS_BATT_UNLIMITED;
         end
         else if (wr_data == `PWRS_RUN_STOP)
         begin
            // Armed but not yet started has no phase to finish
            if (ss == SS_ARMED || ss == SS_IDLE)
            begin
               ss <= SS_IDLE;
               batt_runtime_limit <= `PWRS_BATT_DEFAULT;
            end
            else
               stop_pend <= 1'b1;
         end
      end
      else if (rtc_minute_tick)
      begin
         case (ss)
            SS_ARMED:
               if (midnight)
               begin
                  ss <= SS_ON;
                  on_cnt <= on_minutes;
               end
            SS_ON:
               if (on_cnt <= 8'h01)
               begin
                  if (stop_pend)
                  begin
                     ss <= SS_IDLE;
                     stop_pend <= 1'b0;
                     run_control <= `PWRS_RUN_STOP;
                     batt_runtime_limit <= `PWRS_BATT_DEFAULT;
                  end
                  else
                  begin
                     ss <= SS_OFF;
                     off_cnt <= off_minutes;
                  end
               end
               else
                  on_cnt <= on_cnt - 8'h01;
            SS_OFF:
               if (off_cnt <= 8'h01)
               begin
                  if (stop_pend || cyc_last)
                  begin
                     ss <= SS_IDLE;
                     stop_pend <= 1'b0;
                     cyc_cnt <= 8'h00;
                     run_control <= `PWRS_RUN_STOP;
                     batt_runtime_limit <= `PWRS_BATT_DEFAULT;
                  end
                  else
                  begin
                     ss <= SS_ON;
                     on_cnt <= on_minutes;
                     if (cycle_count != `PWRS_CYC_FOREVER)
                        cyc_cnt <= cyc_cnt - 8'h01;
                  end
               end
               else
                  off_cnt <= off_cnt - 8'h01;
            default: ;
         endcase
      end
   end

   // Event schedules, one engine each
   genvar g;
   generate
      for (g = 0; g < NUM_SCHED; g = g + 1)
      begin : g_sched
         wire [63:0] cfg = ev_cfg[g*64 +: 64];
         wire [1:0] tgt = cfg[`PWRS_EVC_TGT];
         pwrs_evsched u_sched (
            .clk(clk),
            .rst_n(rst_n),
            .run(ev_running),
            .tick(rtc_minute_tick),
            .hour(rtc_hour),
            .minute(rtc_minute),
            .ext_event(ext_event[g]),
            .ctrl(cfg[8*`PWRS_EVF_CTRL +: 8]),
            .start_hour(cfg[8*`PWRS_EVF_HOUR +: 8]),
            .start_min(cfg[8*`PWRS_EVF_MIN +: 8]),
            .dur(cfg[8*`PWRS_EVF_DUR +: 8]),
            .rep(cfg[8*`PWRS_EVF_REP +: 8]),
            .mult(cfg[8*`PWRS_EVF_MULT +: 8]),
            .seq_hours(cfg[8*`PWRS_EVF_SEQ +: 8]),
            .act(ev_act[g])
         );
         assign ev_host[g] = ev_act[g] && tgt == `PWRS_TGT_HOST;
         assign ev_aux[g] = ev_act[g] && tgt == `PWRS_TGT_AUX;
         assign ev_relay[g] = ev_act[g] && tgt == `PWRS_TGT_RELAY;
      end
   endgenerate

   // Power outputs; relay is bistable so it only sees a pulse on each change
   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         host_power_en <= 1'b0;
         aux_5v_en <= 1'b0;
         relay_state <= 1'b0;
         relay_set <= 1'b0;
         relay_reset <= 1'b0;
      end
      else
      begin
         host_power_en <= ss == SS_ON || |ev_host;
         aux_5v_en <= |ev_aux;
         relay_state <= |ev_relay;
         relay_set <= |ev_relay && !relay_state;
         relay_reset <= !(|ev_relay) && relay_state;
      end
   end

   // Indicator blink; counter waits at zero while idle so the first flash is whole
   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         led_cnt <= 27'h0000000;
         information_indicator <= 1'b0;
      end
      else
      begin
         if (!(simple_active && cable_powered) || led_cnt >= LED_PERIOD_CYC - 1)
            led_cnt <= 27'h0000000;
         else
            led_cnt <= led_cnt + 27'h0000001;
         information_indicator <= simple_active && cable_powered &&
            led_cnt < LED_FLASH_CYC;
      end
   end

   // Read mux; running counters are shown so software sees time passing
   always @*
   begin
      rd_data = 8'h00;
      if (ptr == `PWRS_OFS_SELECT)
         rd_data = scheduler_select;
      else if (ptr == `PWRS_OFS_ON)
         rd_data = (ss == SS_ON) ? on_cnt : on_minutes;
      else if (ptr == `PWRS_OFS_OFF)
         rd_data = (ss == SS_OFF) ? off_cnt : off_minutes;
      else if (ptr == `PWRS_OFS_CYCLES)
         rd_data = (simple_active && cycle_count != `PWRS_CYC_FOREVER) ? cyc_cnt :
            cycle_count;
      else if (ptr == `PWRS_OFS_RUN)
         rd_data = run_control;
      else if (ptr == `PWRS_OFS_EV_RUN)
         rd_data = {7'h00, event_run};
      else if (ptr == `PWRS_OFS_STATUS)
         rd_data = {ev_act[3:0], stop_pend, ev_running, ss};
      else if (in_ev_area)
         rd_data = ev_cfg[{ptr[4:0], 3'h0} +: 8];
   end
endmodule

// ===== tb_top.sv
// Self-checking bench for the power scheduler
`timescale 1ns/1ps
module tb_top;
   // Rows: write flag, offset, value written, value read back
   localparam [31:0] ROWS [0:10] = '{32'h00200001, 32'h00210001, 32'h00220001,
      32'h002300ff, 32'h00240000, 32'h01210303, 32'h01220202, 32'h01236464,
      32'h01220002, 32'h01305a00, 32'h01200101};
   // Aux on a time, relay on an event, a disabled host schedule, then run
   // Then stop, a repeating aux schedule on slot 3, and run again
   localparam [15:0] EVS [0:17] = '{16'h4803, 16'h4905, 16'h4b02, 16'h4d01,
      16'h500d, 16'h5301, 16'h5501, 16'h4008, 16'h2801, 16'h2800, 16'h5803, 16'h5905,
      16'h5a02, 16'h5b01, 16'h5c02, 16'h5d02, 16'h5e01, 16'h2801};
   reg clk = 1'b0;
   reg rst_n = 1'b0;
   reg tick = 1'b0;
   reg [7:0] hour = 8'h00;
   reg [7:0] minute = 8'h00;
   reg cable = 1'b1;
   reg [3:0] ext = 4'h0;
   wire scl, sda_low, sda_out, sda_oe, host_on, aux_on, rly_set, rly_rst, ind;
   wire [7:0] batt;
   // Pulled-up line: low when either party pulls it
   wire sda = ~sda_low & (~sda_oe | sda_out);
   integer num_errors = 0;
   integer samples_checked = 0;
   integer cyc = 0;
   integer n_set, n_rst, n_ind, i;
   reg [7:0] rv;
   pwrs_top #(.LED_FLASH_CYC(5), .LED_PERIOD_CYC(20)) dut_u (.clk(clk), .rst_n(rst_n),
      .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
      .rtc_minute_tick(tick), .rtc_hour(hour), .rtc_minute(minute), .cable_powered(cable),
      .ext_event(ext), .host_power_en(host_on), .aux_5v_en(aux_on), .relay_set(rly_set),
      .relay_reset(rly_rst), .information_indicator(ind), .batt_runtime_limit(batt));
   pwrs_host_model host_u (.clk(clk), .sda_in(sda), .scl(scl), .sda_low(sda_low));
   initial
      forever #4 clk = ~clk;
   always @(posedge clk)
   begin
      cyc = cyc + 1;
      if (cyc == 40000)
      begin
         num_errors = num_errors + 1;
         results;
      end
   end
   task chk(input string n, input [7:0] e, input [7:0] g);
   begin
      samples_checked = samples_checked + 1;
      if (g !== e)
      begin
         num_errors = num_errors + 1;
         $display("MISMATCH %0s expected %h seen %h", n, e, g);
      end
   end
   endtask
   // One-cycle minute tick, then count relay pulses while outputs settle
   task mtick;
   begin
      n_set = 0;
      n_rst = 0;
      tick = 1'b1;
      @(negedge clk);
      tick = 1'b0;
      repeat (6)
      begin
         @(negedge clk);
         n_set = n_set + rly_set;
         n_rst = n_rst + rly_rst;
      end
   end
   endtask
   task results;
   begin
      $display("errors %0d checks %0d", num_errors, samples_checked);
      if (num_errors == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   end
   endtask
   initial
   begin
      repeat (3) @(negedge clk);
      rst_n = 1'b1;
      @(negedge clk);
      chk("batt", 8'h01, batt);
      for (i = 0; i < 11; i = i + 1)
      begin
         if (ROWS[i][24])
            host_u.wr(ROWS[i][23:16], ROWS[i][15:8]);
         chk("ack", 8'h00, {7'h0, host_u.nak});
         host_u.rd(ROWS[i][23:16], rv);
         chk("reg", ROWS[i][7:0], rv);
      end
      host_u.wr(8'h21, 8'h01);
      host_u.wr(8'h22, 8'h01);
      host_u.wr(8'h23, 8'h02);
      host_u.wr(8'h24, 8'hff);
      chk("host", 8'h01, {7'h0, host_on});
      chk("batt", 8'hff, batt);
      n_ind = 0;
      repeat (20)
      begin
         @(negedge clk);
         n_ind = n_ind + ind;
      end
      chk("flash", 8'h05, n_ind[7:0]);
      for (i = 0; i < 4; i = i + 1)
      begin
         mtick;
         chk("phase", {7'h0, i == 1}, {7'h0, host_on});
      end
      chk("batt", 8'h01, batt);
      host_u.rd(8'h24, rv);
      chk("run", 8'h00, rv);
      // Programming is refused on battery power
      cable = 1'b0;
      host_u.wr(8'h21, 8'h07);
      cable = 1'b1;
      host_u.rd(8'h21, rv);
      chk("on_min", 8'h01, rv);
      hour = 8'h17;
      minute = 8'h3b;
      host_u.wr(8'h24, 8'hfb);
      mtick;
      chk("armed", 8'h00, {7'h0, host_on});
      hour = 8'h00;
      minute = 8'h00;
      mtick;
      chk("midnight", 8'h01, {7'h0, host_on});
      host_u.wr(8'h24, 8'h00);
      chk("stopping", 8'h01, {7'h0, host_on});
      mtick;
      chk("stopped", 8'h00, {7'h0, host_on});
      host_u.wr(8'h20, 8'h02);
      for (i = 0; i < 9; i = i + 1)
         host_u.wr(EVS[i][15:8], EVS[i][7:0]);
      hour = 8'h05;
      ext = 4'h5;
      mtick;
      chk("aux_on", 8'h01, {7'h0, aux_on});
      chk("set", 8'h01, n_set[7:0]);
      chk("host_off", 8'h00, {7'h0, host_on});
      ext = 4'h0;
      minute = 8'h01;
      mtick;
      chk("rly_reset", 8'h01, n_rst[7:0]);
      chk("aux_held", 8'h01, {7'h0, aux_on});
      mtick;
      chk("aux_off", 8'h00, {7'h0, aux_on});
      for (i = 9; i < 18; i = i + 1)
         host_u.wr(EVS[i][15:8], EVS[i][7:0]);
      minute = 8'h02;
      // Two occurrences two minutes apart, then the sequence again an hour on
      for (i = 0; i < 61; i = i + 1)
      begin
         mtick;
         chk("repeat", {7'h0, i == 0 || i == 2 || i == 60}, {7'h0, aux_on});
      end
      results;
   end
endmodule
bind pwrs_top pwrs_sched_properties #(.LED_FLASH_CYC(LED_FLASH_CYC),
   .LED_PERIOD_CYC(LED_PERIOD_CYC)) chk_u (.clk(clk), .rst_n(rst_n),
   .rtc_minute_tick(rtc_minute_tick), .host_power_en(host_power_en), .aux_5v_en(aux_5v_en),
   .relay_set(relay_set), .relay_reset(relay_reset),
   .information_indicator(information_indicator), .batt_runtime_limit(batt_runtime_limit));
